// [hdl/sssel_pkg.sv]
// Constants, field layout and encodings shared by the stop-sequence selector.
`default_nettype none
package sssel_pkg;
    // Byte offsets of the register words.
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_GEAR2 = 6'h04;
    localparam logic [5:0] REG_GEAR3 = 6'h08;
    localparam logic [5:0] REG_GEAR4 = 6'h0C;
    localparam logic [5:0] REG_PPR = 6'h10;
    localparam logic [5:0] REG_ESTOP_TQ = 6'h14;
    localparam logic [5:0] REG_STATE = 6'h18;
    localparam logic [5:0] REG_IRQ_STAT = 6'h1C;
    localparam logic [5:0] REG_IRQ_MASK = 6'h20;
    // Control word fields.
    localparam int CTRL_OT_SET_LSB = 0;
    localparam int CTRL_OT_SEQ_LSB = 2;
    localparam int CTRL_SOFF_SEQ_LSB = 4;
    localparam int CTRL_ALM_SEQ_LSB = 8;
    localparam int CTRL_MODE_LSB = 12;
    localparam int CTRL_GEAR_SEL_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] GEAR_RESET = 32'h0000_0000;
    localparam logic [31:0] PPR_RESET = 32'h0000_0000;
    localparam logic [8:0] ESTOP_TQ_RESET = 9'h000;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    // State word fields.
    localparam int STATE_CAUSE_LSB = 4;
    localparam int STATE_INHIBIT_BIT = 8;
    localparam int STATE_POS_BIT = 9;
    localparam int STATE_NEG_BIT = 10;
    // Control modes.
    localparam logic [1:0] MODE_POS = 2'h0;
    localparam logic [1:0] MODE_VEL = 2'h1;
    localparam logic [1:0] MODE_TRQ = 2'h2;
    localparam logic [1:0] MODE_FC = 2'h3;
    // Over-travel setting values.
    localparam logic [1:0] OT_AXIS = 2'h0;
    localparam logic [1:0] OT_OFF = 2'h1;
    localparam logic [1:0] OT_ALARM = 2'h2;
    // Over-travel stop sequences.
    localparam logic [1:0] OTSEQ_DB = 2'h0;
    localparam logic [1:0] OTSEQ_ZT = 2'h1;
    localparam logic [1:0] OTSEQ_ESTOP = 2'h2;
    // Stop causes, highest code wins.
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_OT = 2'h1;
    localparam logic [1:0] CAUSE_SOFF = 2'h2;
    localparam logic [1:0] CAUSE_ALARM = 2'h3;
    // Interrupt status bits.
    localparam int IRQ_W = 4;
    localparam int IRQ_INHIBIT = 0;
    localparam int IRQ_STOP_BEGIN = 1;
    localparam int IRQ_STOPPED = 2;
    localparam int IRQ_DEV_CLR = 3;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_DECEL = 3'b010,
        ST_STOP = 3'b100
    } sssel_state_e;
endpackage
`default_nettype wire

// [hdl/sssel_top.sv]
// Stop-sequence selector with gear numerator substitution and an Avalon-MM register slave.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Position mode: zero numerator uses encoder resolution.
// - Full-closed: zero numerator forces ratio one.
// - Alternate numerators need zero PPR or full-closed.
// - Over-travel: 0 axis block, 1 ignore, 2 alarm.
// - Setting 2: any inhibit raises run-inhibit alarm.
// - Over-travel sequence only acts when setting zero.
// - Sequence 0/1: brake or zero torque, hold.
// - Sequence 2: emergency stop, zero command, clear twice.
// - Zero command kind follows the control mode.
// - Alarm sequence overrides the over-travel sequence.
// - Emergency stop keeps servo on, torque limited.
// - Below 30 r/min deceleration ends until the stop cause changes.
// - Servo-off 0..3 clear; bits pick free-run.
// - Servo-off 4..7 same braking, deviation held.
// - Servo-off 8/9 emergency stop, clear, then brake/free.
// - Zero emergency torque uses normal torque limit.
module sssel_top #(
    parameter int GEAR_W = 31,
    parameter logic [30:0] ENCODER_RESOLUTION = 31'h0010_0000
) (
    // Clock, reset and enable.
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Avalon-MM register slave.
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Travel inhibit pins.
    input wire logic positive_travel_inhibit,
    input wire logic negative_travel_inhibit,
    // Drive status from neighbouring logic.
    input wire logic servo_on,
    input wire logic alarm_active,
    input wire logic alarm_needs_estop,
    input wire logic speed_below_threshold,
    input wire logic [8:0] normal_torque_limit,
    input wire logic [30:0] gear_numerator_first,
    input wire logic [30:0] gear_denominator_first,
    // Gear ratio in use.
    output logic [30:0] gear_num_q,
    output logic [30:0] gear_den_q,
    // Stop actions.
    output logic block_positive_q,
    output logic block_negative_q,
    output logic dynamic_brake_q,
    output logic emergency_stop_q,
    output logic zero_torque_inhibited_q,
    output logic zero_position_command_q,
    output logic zero_speed_command_q,
    output logic zero_speed_limit_q,
    output logic deviation_clear_q,
    output logic run_inhibit_alarm_q,
    output logic [8:0] torque_limit_q,
    // Interrupt.
    output logic irq
);
    logic [31:0] ctrl_q;
    logic [31:0] gear2_q;
    logic [31:0] gear3_q;
    logic [31:0] gear4_q;
    logic [31:0] ppr_q;
    logic [8:0] estop_tq_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic ack_q;
    logic [1:0] pos_sync_q;
    logic [1:0] neg_sync_q;
    logic pot_s;
    logic neg_s;
    logic [1:0] cause_q;
    logic [1:0] cause_d;
    sssel_pkg::sssel_state_e state_q;
    sssel_pkg::sssel_state_e state_d;
    logic [1:0] ot_set;
    logic [1:0] ot_seq;
    logic [3:0] soff_seq;
    logic [2:0] alm_seq;
    logic [1:0] mode;
    logic [1:0] gear_sel;
    logic run_inh;
    logic ot_act;
    logic db_d;
    logic estop_d;
    logic zt_d;
    logic zc_d;
    logic devclr_d;
    logic dev_pulse;
    logic alt_on;
    logic [30:0] alt_num;
    logic [30:0] num_d;
    logic [30:0] den_d;
    logic [3:0] irq_ev;
    logic wr_go;
    logic rd_go;

    // Merges write data into a word under the byte enables.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign ot_set = ctrl_q[sssel_pkg::CTRL_OT_SET_LSB +: 2];
    assign ot_seq = ctrl_q[sssel_pkg::CTRL_OT_SEQ_LSB +: 2];
    assign soff_seq = ctrl_q[sssel_pkg::CTRL_SOFF_SEQ_LSB +: 4];
    assign alm_seq = ctrl_q[sssel_pkg::CTRL_ALM_SEQ_LSB +: 3];
    assign mode = ctrl_q[sssel_pkg::CTRL_MODE_LSB +: 2];
    assign gear_sel = ctrl_q[sssel_pkg::CTRL_GEAR_SEL_LSB +: 2];

    // Bus handshake answers one cycle after the request is seen.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_go = clk_en & avs_write & ack_q;
    assign rd_go = clk_en & avs_read & ~ack_q;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (rd_go)
        begin
            unique case (avs_address)
                sssel_pkg::REG_CTRL: avs_readdata <= ctrl_q;
                sssel_pkg::REG_GEAR2: avs_readdata <= gear2_q;
                sssel_pkg::REG_GEAR3: avs_readdata <= gear3_q;
                sssel_pkg::REG_GEAR4: avs_readdata <= gear4_q;
                sssel_pkg::REG_PPR: avs_readdata <= ppr_q;
                sssel_pkg::REG_ESTOP_TQ: avs_readdata <= {23'h000000, estop_tq_q};
                sssel_pkg::REG_STATE: avs_readdata <= {21'h000000, neg_s, pot_s, run_inhibit_alarm_q,
                                                       2'h0, cause_q, 1'b0, state_q};
                sssel_pkg::REG_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_q};
                sssel_pkg::REG_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask_q};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= sssel_pkg::CTRL_RESET;
            gear2_q <= sssel_pkg::GEAR_RESET;
            gear3_q <= sssel_pkg::GEAR_RESET;
            gear4_q <= sssel_pkg::GEAR_RESET;
            ppr_q <= sssel_pkg::PPR_RESET;
            estop_tq_q <= sssel_pkg::ESTOP_TQ_RESET;
            irq_mask_q <= sssel_pkg::IRQ_MASK_RESET;
        end
        else if (wr_go)
        begin
            unique case (avs_address)
                sssel_pkg::REG_CTRL: ctrl_q <= merge_bytes(ctrl_q, avs_writedata, avs_byteenable);
                sssel_pkg::REG_GEAR2: gear2_q <= merge_bytes(gear2_q, avs_writedata, avs_byteenable);
                sssel_pkg::REG_GEAR3: gear3_q <= merge_bytes(gear3_q, avs_writedata, avs_byteenable);
                sssel_pkg::REG_GEAR4: gear4_q <= merge_bytes(gear4_q, avs_writedata, avs_byteenable);
                sssel_pkg::REG_PPR: ppr_q <= merge_bytes(ppr_q, avs_writedata, avs_byteenable);
                sssel_pkg::REG_ESTOP_TQ: estop_tq_q <= 9'(merge_bytes({23'h000000, estop_tq_q}, avs_writedata,
                                                                     avs_byteenable));
                sssel_pkg::REG_IRQ_MASK: irq_mask_q <= 4'(merge_bytes({28'h0000000, irq_mask_q}, avs_writedata,
                                                                     avs_byteenable));
                default: ;
            endcase
        end
    end

    // Inhibit pins pass two flip-flops before use.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pos_sync_q <= 2'h0;
            neg_sync_q <= 2'h0;
        end
        else if (clk_en)
        begin
            pos_sync_q <= {pos_sync_q[0], positive_travel_inhibit};
            neg_sync_q <= {neg_sync_q[0], negative_travel_inhibit};
        end
    end
    assign pot_s = pos_sync_q[1];
    assign neg_s = neg_sync_q[1];

    // Inhibit decode and cause priority.
    assign run_inh = (ot_set == sssel_pkg::OT_ALARM) & (pot_s | neg_s);
    assign ot_act = (ot_set == sssel_pkg::OT_AXIS) & (pot_s | neg_s);

    always_comb
    begin
        if (alarm_active | run_inh)
        begin
            cause_d = sssel_pkg::CAUSE_ALARM;
        end
        else if (!servo_on)
        begin
            cause_d = sssel_pkg::CAUSE_SOFF;
        end
        else if (ot_act)
        begin
            cause_d = sssel_pkg::CAUSE_OT;
        end
        else
        begin
            cause_d = sssel_pkg::CAUSE_NONE;
        end
    end

    // Deceleration ends at the first slow-speed indication and returns only when the stop cause changes.
    always_comb
    begin
        if (cause_d == sssel_pkg::CAUSE_NONE)
        begin
            state_d = sssel_pkg::ST_RUN;
        end
        else if (cause_d != cause_q)
        begin
            state_d = sssel_pkg::ST_DECEL;
        end
        else
        begin
            unique case (state_q)
                sssel_pkg::ST_RUN: state_d = sssel_pkg::ST_DECEL;
                sssel_pkg::ST_DECEL: state_d = speed_below_threshold ? sssel_pkg::ST_STOP : sssel_pkg::ST_DECEL;
                sssel_pkg::ST_STOP: state_d = sssel_pkg::ST_STOP;
                default: state_d = sssel_pkg::ST_DECEL;
            endcase
        end
    end

    // Braking action for the active cause and phase.
    always_comb
    begin
        db_d = 1'b0;
        estop_d = 1'b0;
        zt_d = 1'b0;
        zc_d = 1'b0;
        devclr_d = 1'b0;
        unique case (cause_d)
            sssel_pkg::CAUSE_OT:
            begin
                if (state_d == sssel_pkg::ST_DECEL)
                begin
                    estop_d = (ot_seq == sssel_pkg::OTSEQ_ESTOP);
                    zt_d = (ot_seq == sssel_pkg::OTSEQ_ZT);
                    db_d = (ot_seq != sssel_pkg::OTSEQ_ZT) & (ot_seq != sssel_pkg::OTSEQ_ESTOP);
                end
                else
                begin
                    zc_d = (ot_seq == sssel_pkg::OTSEQ_ESTOP);
                    zt_d = (ot_seq != sssel_pkg::OTSEQ_ESTOP);
                end
            end
            sssel_pkg::CAUSE_SOFF:
            begin
                devclr_d = ~soff_seq[2] | soff_seq[3];
                if (soff_seq[3])
                begin
                    estop_d = (state_d == sssel_pkg::ST_DECEL);
                    db_d = (state_d == sssel_pkg::ST_STOP) & ~soff_seq[0];
                end
                else
                begin
                    db_d = (state_d == sssel_pkg::ST_DECEL) ? ~soff_seq[0] : ~soff_seq[1];
                end
            end
            sssel_pkg::CAUSE_ALARM:
            begin
                if (state_d == sssel_pkg::ST_DECEL)
                begin
                    estop_d = alm_seq[2] & alarm_needs_estop;
                    db_d = ~(alm_seq[2] & alarm_needs_estop) & ~alm_seq[0];
                end
                else
                begin
                    db_d = ~alm_seq[1];
                end
            end
            default: ;
        endcase
    end

    // Clearing pulses at the start and the end of an over-travel emergency deceleration.
    assign dev_pulse = (cause_d == sssel_pkg::CAUSE_OT) & (ot_seq == sssel_pkg::OTSEQ_ESTOP) &
                       (((state_d == sssel_pkg::ST_DECEL) & ((state_q != sssel_pkg::ST_DECEL) | (cause_q != cause_d))) |
                        ((state_d == sssel_pkg::ST_STOP) & (state_q == sssel_pkg::ST_DECEL)));

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= sssel_pkg::ST_RUN;
            cause_q <= sssel_pkg::CAUSE_NONE;
            dynamic_brake_q <= 1'b0;
            emergency_stop_q <= 1'b0;
            zero_torque_inhibited_q <= 1'b0;
            zero_position_command_q <= 1'b0;
            zero_speed_command_q <= 1'b0;
            zero_speed_limit_q <= 1'b0;
            deviation_clear_q <= 1'b0;
            run_inhibit_alarm_q <= 1'b0;
            block_positive_q <= 1'b0;
            block_negative_q <= 1'b0;
            torque_limit_q <= 9'h000;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            cause_q <= cause_d;
            dynamic_brake_q <= db_d;
            emergency_stop_q <= estop_d;
            zero_torque_inhibited_q <= zt_d;
            zero_position_command_q <= zc_d & ((mode == sssel_pkg::MODE_POS) | (mode == sssel_pkg::MODE_FC));
            zero_speed_command_q <= zc_d & (mode == sssel_pkg::MODE_VEL);
            zero_speed_limit_q <= zc_d & (mode == sssel_pkg::MODE_TRQ);
            deviation_clear_q <= devclr_d | dev_pulse;
            run_inhibit_alarm_q <= run_inh;
            block_positive_q <= (cause_d == sssel_pkg::CAUSE_OT) & pot_s;
            block_negative_q <= (cause_d == sssel_pkg::CAUSE_OT) & neg_s;
            torque_limit_q <= (estop_d && estop_tq_q != 9'h000) ? estop_tq_q : normal_torque_limit;
        end
    end

    // Gear numerator choice and zero substitution.
    always_comb
    begin
        unique case (gear_sel)
            2'h1: alt_num = gear2_q[30:0];
            2'h2: alt_num = gear3_q[30:0];
            2'h3: alt_num = gear4_q[30:0];
            default: alt_num = gear_numerator_first;
        endcase
    end
    assign alt_on = (gear_sel != 2'h0) & ((ppr_q == 32'h0000_0000) | (mode == sssel_pkg::MODE_FC));

    always_comb
    begin
        num_d = gear_numerator_first;
        den_d = gear_denominator_first;
        if (alt_on)
        begin
            num_d = alt_num;
            if (alt_num == 31'h0000_0000)
            begin
                if (mode == sssel_pkg::MODE_FC)
                begin
                    num_d = 31'h0000_0001;
                    den_d = 31'h0000_0001;
                end
                else
                begin
                    num_d = ENCODER_RESOLUTION;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gear_num_q <= 31'h0000_0000;
            gear_den_q <= 31'h0000_0000;
        end
        else if (clk_en)
        begin
            gear_num_q <= num_d;
            gear_den_q <= den_d;
        end
    end

    // Sticky interrupt status, set wins over write-one clear.
    assign irq_ev[sssel_pkg::IRQ_INHIBIT] = run_inh & ~run_inhibit_alarm_q;
    assign irq_ev[sssel_pkg::IRQ_STOP_BEGIN] = (state_d == sssel_pkg::ST_DECEL) & (state_q == sssel_pkg::ST_RUN);
    assign irq_ev[sssel_pkg::IRQ_STOPPED] = (state_d == sssel_pkg::ST_STOP) & (state_q != sssel_pkg::ST_STOP);
    assign irq_ev[sssel_pkg::IRQ_DEV_CLR] = dev_pulse;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_stat_q <= 4'h0;
        end
        else if (clk_en)
        begin
            if (wr_go && avs_address == sssel_pkg::REG_IRQ_STAT && avs_byteenable[0])
            begin
                irq_stat_q <= (irq_stat_q & ~avs_writedata[3:0]) | irq_ev;
            end
            else
            begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_ot_estop_entry;
        clk_en && cause_d == sssel_pkg::CAUSE_OT && ot_seq == sssel_pkg::OTSEQ_ESTOP && state_q == sssel_pkg::ST_RUN;
    endsequence
    sequence s_clear_pulse;
        deviation_clear_q && emergency_stop_q;
    endsequence

    property p_gear_pos_zero;
        clk_en && alt_on && alt_num == 31'h0000_0000 && mode == sssel_pkg::MODE_POS |=> gear_num_q == ENCODER_RESOLUTION;
    endproperty
    a_gear_pos_zero: assert property (p_gear_pos_zero) else $error("zero numerator not replaced");

    property p_gear_fc_zero;
        clk_en && alt_on && alt_num == 31'h0000_0000 && mode == sssel_pkg::MODE_FC |=> gear_num_q == 31'h0000_0001 && gear_den_q == 31'h0000_0001;
    endproperty
    a_gear_fc_zero: assert property (p_gear_fc_zero) else $error("full-closed ratio not one");

    property p_gear_gate;
        clk_en && ppr_q != 32'h0000_0000 && mode != sssel_pkg::MODE_FC |=> gear_num_q == $past(gear_numerator_first);
    endproperty
    a_gear_gate: assert property (p_gear_gate) else $error("alternate numerator used while gated");

    property p_ot_ignored;
        clk_en && ot_set == sssel_pkg::OT_OFF |=> !block_positive_q && !block_negative_q && !run_inhibit_alarm_q;
    endproperty
    a_ot_ignored: assert property (p_ot_ignored) else $error("inhibit acted while disabled");

    property p_run_inhibit;
        clk_en && ot_set == sssel_pkg::OT_ALARM && (pot_s || neg_s) |=> run_inhibit_alarm_q && cause_q == sssel_pkg::CAUSE_ALARM;
    endproperty
    a_run_inhibit: assert property (p_run_inhibit) else $error("run-inhibit alarm missing");

    property p_ot_estop_clear;
        s_ot_estop_entry |=> s_clear_pulse;
    endproperty
    a_ot_estop_clear: assert property (p_ot_estop_clear) else $error("no clear at deceleration start");

    property p_stop_sticky;
        clk_en && state_q == sssel_pkg::ST_STOP && cause_d == cause_q |=> state_q == sssel_pkg::ST_STOP;
    endproperty
    a_stop_sticky: assert property (p_stop_sticky) else $error("left after-stop state");

    property p_estop_torque;
        clk_en && estop_d && estop_tq_q == 9'h000 |=> emergency_stop_q && torque_limit_q == $past(normal_torque_limit);
    endproperty
    a_estop_torque: assert property (p_estop_torque) else $error("zero setting did not use normal limit");

    property p_soff_hold;
        clk_en && cause_d == sssel_pkg::CAUSE_SOFF && soff_seq[3:2] == 2'h1 |=> !deviation_clear_q;
    endproperty
    a_soff_hold: assert property (p_soff_hold) else $error("deviation cleared while held");

    property p_slow_switch;
        clk_en && state_q == sssel_pkg::ST_DECEL && cause_d == cause_q && speed_below_threshold |=> state_q == sssel_pkg::ST_STOP;
    endproperty
    a_slow_switch: assert property (p_slow_switch) else $error("slow speed did not end deceleration");
endmodule // sssel_top
`default_nettype wire

// [bench/sssel_host.sv]
// Host controller model that drives the two travel-inhibit pins.
`timescale 1ns/1ps
`default_nettype none
module sssel_host (
    // Clock and requests from the bench.
    input wire logic sys_clk,
    input wire logic pos_req,
    input wire logic neg_req,
    // Travel inhibit pins.
    output logic positive_travel_inhibit,
    output logic negative_travel_inhibit
);
    initial positive_travel_inhibit = 1'b0;
    initial negative_travel_inhibit = 1'b0;
    // Each inhibit pin follows its bench request one clock later.
    always @(posedge sys_clk)
    begin
        positive_travel_inhibit <= pos_req;
        negative_travel_inhibit <= neg_req;
    end
endmodule // sssel_host
`default_nettype wire

// [bench/sssel_tb.sv]
// Self-checking testbench of the stop-sequence selector.
`timescale 1ns/1ps
`default_nettype none
module sssel_tb;
    logic sys_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, pti, nti, irq;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic servo_on = 1'b1, alarm_active = 1'b0, speed_below = 1'b0, pos_req = 1'b0, neg_req = 1'b0;
    logic [30:0] num, den;
    logic bp, bn, zt, es, db, zp, dc, ria;
    logic [8:0] tl, ntl = 9'h0AB;
    int n_fail = 0, total_checks = 0, cycles = 0;
    always #25 sys_clk = ~sys_clk;
    sssel_host host (.sys_clk(sys_clk), .pos_req(pos_req), .neg_req(neg_req),
        .positive_travel_inhibit(pti), .negative_travel_inhibit(nti));
    sssel_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .positive_travel_inhibit(pti),
        .negative_travel_inhibit(nti), .servo_on(servo_on), .alarm_active(alarm_active),
        .alarm_needs_estop(1'b0), .speed_below_threshold(speed_below), .normal_torque_limit(ntl),
        .gear_numerator_first(31'h0000_0007), .gear_denominator_first(31'h0000_0003), .gear_num_q(num),
        .gear_den_q(den), .block_positive_q(bp), .block_negative_q(bn), .dynamic_brake_q(db),
        .emergency_stop_q(es), .zero_torque_inhibited_q(zt), .zero_position_command_q(zp),
        .zero_speed_command_q(), .zero_speed_limit_q(), .deviation_clear_q(dc), .run_inhibit_alarm_q(ria),
        .torque_limit_q(tl), .irq(irq));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_reset;
        bus(1'b0, sssel_pkg::REG_CTRL, 32'h0);
        chk("ctrl", q, sssel_pkg::CTRL_RESET);
        bus(1'b0, 6'h3C, 32'h0);
        chk("unmapped", q, 32'h0);
    endtask
    task automatic t_ot_estop;
        bus(1'b1, sssel_pkg::REG_ESTOP_TQ, 32'h0000_0050);
        bus(1'b1, sssel_pkg::REG_IRQ_MASK, 32'h0000_000F);
        bus(1'b1, sssel_pkg::REG_CTRL, 32'h0000_0008);
        @(posedge sys_clk) pos_req <= 1'b1;
        w(5);
        chk("estop", 32'(es), 32'h1);
        chk("block_pos", 32'(bp), 32'h1);
        chk("torque", 32'(tl), 32'h50);
        chk("irq", 32'(irq), 32'h1);
        @(posedge sys_clk) speed_below <= 1'b1;
        w(2);
        chk("zero_pos", 32'(zp), 32'h1);
        chk("estop_end", 32'(es), 32'h0);
        @(posedge sys_clk) speed_below <= 1'b0;
        w(2);
        chk("zero_pos_kept", 32'(zp), 32'h1);
        @(posedge sys_clk) alarm_active <= 1'b1;
        w(2);
        bus(1'b0, sssel_pkg::REG_STATE, 32'h0);
        chk("cause", 32'(q[5:4]), 32'(sssel_pkg::CAUSE_ALARM));
        @(posedge sys_clk) alarm_active <= 1'b0;
        @(posedge sys_clk) pos_req <= 1'b0;
        w(4);
        bus(1'b1, sssel_pkg::REG_IRQ_STAT, 32'h0000_000F);
        w(1);
        chk("irq_clr", 32'(irq), 32'h0);
    endtask
    task automatic t_ot_alarm;
        bus(1'b1, sssel_pkg::REG_CTRL, 32'h0000_0002);
        @(posedge sys_clk) neg_req <= 1'b1;
        w(5);
        chk("run_inhibit", 32'(ria), 32'h1);
        chk("block_neg_alarm", 32'(bn), 32'h0);
        chk("irq_inhibit", 32'(irq), 32'h1);
        bus(1'b1, sssel_pkg::REG_IRQ_MASK, 32'h0);
        w(1);
        chk("irq_masked", 32'(irq), 32'h0);
        @(posedge sys_clk) neg_req <= 1'b0;
        bus(1'b1, sssel_pkg::REG_IRQ_MASK, 32'h0);
        bus(1'b1, sssel_pkg::REG_IRQ_STAT, 32'h0000_000F);
    endtask
    task automatic t_ot_zt;
        bus(1'b1, sssel_pkg::REG_CTRL, 32'h0000_2004);
        @(posedge sys_clk) neg_req <= 1'b1;
        w(5);
        chk("zero_torque", 32'(zt), 32'h1);
        chk("block_neg", 32'(bn), 32'h1);
        chk("no_brake", 32'(db), 32'h0);
        @(posedge sys_clk) neg_req <= 1'b0;
        w(4);
    endtask
    task automatic t_servo_off;
        logic [3:0] seq [3] = '{4'h3, 4'h4, 4'h8};
        bus(1'b1, sssel_pkg::REG_ESTOP_TQ, 32'h0);
        @(posedge sys_clk) ntl <= 9'h123;
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, sssel_pkg::REG_CTRL, {24'h0, seq[i], 4'h1});
            @(posedge sys_clk) servo_on <= 1'b0;
            w(2);
            chk("dev_clear", 32'(dc), 32'(i != 1));
            chk("estop_soff", 32'(es), 32'(i == 2));
            if (i < 2)
                chk("brake", 32'(db), 32'(i == 1));
            else
                chk("torque_norm", 32'(tl), 32'h123);
            @(posedge sys_clk) servo_on <= 1'b1;
            w(2);
        end
    endtask
    task automatic t_gear;
        bus(1'b1, sssel_pkg::REG_CTRL, 32'h0001_3001);
        w(2);
        chk("fc_num", 32'(num), 32'h1);
        chk("fc_den", 32'(den), 32'h1);
        bus(1'b1, sssel_pkg::REG_CTRL, 32'h0001_0001);
        w(2);
        chk("pos_num", 32'(num), 32'h0010_0000);
        chk("pos_den", 32'(den), 32'h3);
        bus(1'b1, sssel_pkg::REG_PPR, 32'h0000_0005);
        w(2);
        chk("ppr_num", 32'(num), 32'h7);
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_ot_estop();
        t_ot_alarm();
        t_ot_zt();
        t_servo_off();
        t_gear();
        report_and_stop();
    end
endmodule // sssel_tb
`default_nettype wire
